//--- core/link_quality_threshold_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module link_quality_threshold_monitor
	import lqm_pkg::*;
#(
	parameter int P_W = lqm_pkg::PARAM_W
) (
	// Clock and reset
	input  wire logic                      i_clk,
	input  wire logic                      i_rst_n,
	// Receiver parameters, same clock domain
	input  wire logic                      i_link_100_valid,
	input  wire logic                      i_param_valid,
	input  wire logic [P_W-1:0]            i_equaliser_coeff_param,
	input  wire logic [P_W-1:0]            i_gain_control_param,
	input  wire logic [P_W-1:0]            i_baseline_wander_param,
	input  wire logic [P_W-1:0]            i_freq_offset_param,
	input  wire logic [P_W-1:0]            i_freq_control_param,
	// Link control and interrupt
	output logic                           o_link_reset,
	output logic                           o_irq,
	// AXI4-Lite write address
	input  wire logic                      i_awvalid,
	output logic                           o_awready,
	input  wire logic [lqm_pkg::ADDR_W-1:0] i_awaddr,
	// AXI4-Lite write data
	input  wire logic                      i_wvalid,
	output logic                           o_wready,
	input  wire logic [lqm_pkg::DATA_W-1:0] i_wdata,
	input  wire logic [3:0]                i_wstrb,
	// AXI4-Lite write response
	output logic                           o_bvalid,
	input  wire logic                      i_bready,
	output logic [1:0]                     o_bresp,
	// AXI4-Lite read address
	input  wire logic                      i_arvalid,
	output logic                           o_arready,
	input  wire logic [lqm_pkg::ADDR_W-1:0] i_araddr,
	// AXI4-Lite read data
	output logic                           o_rvalid,
	input  wire logic                      i_rready,
	output logic [lqm_pkg::DATA_W-1:0]     o_rdata,
	output logic [1:0]                     o_rresp
);
	import lqm_pkg::*;

	localparam logic [7:0] CTRL_ADDR = 8'(CTRL_INDEX * 4);
	localparam logic [7:0] THR_ADDR  = 8'(THR_INDEX * 4);

	logic                   monitor_enable;
	logic [9:0]             warn;
	logic [9:0]             next_warn;
	logic [9:0]             hit;
	logic                   armed;
	logic                   auto_reset_enable;
	logic [NUM_EVENTS-1:0]  irq_status;
	logic [NUM_EVENTS-1:0]  irq_enable;
	logic [NUM_EVENTS-1:0]  irq_set;
	logic [NUM_EVENTS-1:0]  irq_clr;
	logic                   sample_param;
	logic [2:0]             parameter_select;
	logic                   threshold_low_high_select;
	logic [P_W-1:0]         threshold_value_field;
	logic [P_W-1:0]         thr_low  [NUM_PARAMS];
	logic [P_W-1:0]         thr_high [NUM_PARAMS];
	logic [P_W-1:0]         param    [NUM_PARAMS];
	logic [P_W-1:0]         sampled;
	logic                   aw_held;
	logic                   w_held;
	logic [ADDR_W-1:0]      aw_addr;
	logic [DATA_W-1:0]      w_data;
	logic [3:0]             w_strb;
	logic                   do_write;
	logic                   do_read;
	logic                   ctrl_read;
	logic [15:0]            ctrl_word;
	logic [15:0]            thr_word;
	logic [15:0]            thr_merged;

	// Byte-lane merge of a 16-bit register with the incoming write
	function automatic logic [15:0] merge16(input logic [15:0] old,
			input logic [DATA_W-1:0] data, input logic [3:0] strb);
		logic [15:0] res;
		res = old;
		if (strb[0]) begin
			res[7:0] = data[7:0];
		end
		if (strb[1]) begin
			res[15:8] = data[15:8];
		end
		return res;
	endfunction

	// A parameter crosses a threshold unless that threshold sits at the
	// extreme, which is how software disables one side
	function automatic logic [1:0] check(input logic [P_W-1:0] value,
			input logic [P_W-1:0] low, input logic [P_W-1:0] high);
		logic [1:0] res;
		res[1] = (high != PARAM_MAX) && (value > high);
		res[0] = (low != PARAM_MIN) && (value < low);
		return res;
	endfunction

	assign param[SEL_EQ_COEFF]    = i_equaliser_coeff_param;
	assign param[SEL_GAIN]        = i_gain_control_param;
	assign param[SEL_WANDER]      = i_baseline_wander_param;
	assign param[SEL_FREQ_OFFSET] = i_freq_offset_param;
	assign param[SEL_FREQ_CTRL]   = i_freq_control_param;

	// Bit pair 2k+1:2k holds parameter k
	always_comb begin
		hit = '0;
		for (int k = 0; k < NUM_PARAMS; k++) begin
			hit[2*k +: 2] = check(param[k], thr_low[k], thr_high[k]);
		end
		if (!(monitor_enable && i_link_100_valid && i_param_valid)) begin
			hit = '0;
		end
	end

	// AXI4-Lite handshakes
	assign o_awready = !aw_held;
	assign o_wready  = !w_held;
	assign o_arready = !o_rvalid;
	assign do_write  = aw_held && w_held && !o_bvalid;
	assign do_read   = i_arvalid && o_arready;
	assign ctrl_read = do_read && (i_araddr == CTRL_ADDR);

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			aw_addr <= '0;
			w_data  <= '0;
			w_strb  <= '0;
		end else begin
			if (i_awvalid && o_awready) begin
				aw_held <= 1'b1;
				aw_addr <= i_awaddr;
			end else if (do_write) begin
				aw_held <= 1'b0;
			end
			if (i_wvalid && o_wready) begin
				w_held <= 1'b1;
				w_data <= i_wdata;
				w_strb <= i_wstrb;
			end else if (do_write) begin
				w_held <= 1'b0;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_bvalid <= 1'b0;
			o_bresp  <= RESP_OKAY;
		end else if (do_write) begin
			o_bvalid <= 1'b1;
			case (aw_addr)
				CTRL_ADDR, THR_ADDR, AUTO_ADDR, IRQ_STAT_ADDR,
				IRQ_EN_ADDR, IRQ_CLR_ADDR: o_bresp <= RESP_OKAY;
				default: o_bresp <= RESP_SLVERR;
			endcase
		end else if (i_bready) begin
			o_bvalid <= 1'b0;
		end
	end

	// Control register writes; reserved and warning bits take nothing
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			monitor_enable <= 1'b0;
		end else if (do_write && aw_addr == CTRL_ADDR && w_strb[1]) begin
			monitor_enable <= w_data[ENABLE_BIT];
		end
	end

	// Threshold data register as it stands once this write lands
	assign thr_merged = merge16(thr_word, w_data, w_strb);

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sample_param              <= 1'b0;
			parameter_select          <= SEL_EQ_COEFF;
			threshold_low_high_select <= 1'b0;
			threshold_value_field     <= '0;
		end else if (do_write && aw_addr == THR_ADDR) begin
			sample_param              <= thr_merged[SAMPLE_BIT];
			parameter_select          <= thr_merged[SEL_LSB +: 3];
			threshold_low_high_select <= thr_merged[HILO_BIT];
			threshold_value_field     <= thr_merged[P_W-1:0];
		end
	end

	// Threshold store; the strobe itself is never held, so it reads zero
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			for (int k = 0; k < NUM_PARAMS; k++) begin
				thr_low[k]  <= THR_LOW_RESET;
				thr_high[k] <= THR_HIGH_RESET;
			end
		end else if (do_write && aw_addr == THR_ADDR && w_strb[1]
				&& w_data[WRITE_BIT]) begin
			for (int k = 0; k < NUM_PARAMS; k++) begin
				if (w_data[SEL_LSB +: 3] == 3'(k)) begin
					if (w_data[HILO_BIT]) begin
						thr_high[k] <= thr_merged[P_W-1:0];
					end else begin
						thr_low[k] <= thr_merged[P_W-1:0];
					end
				end
			end
		end
	end

	// Sampled copy of the selected parameter for software to read
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sampled <= '0;
		end else if (sample_param && parameter_select < 3'(NUM_PARAMS)) begin
			sampled <= param[parameter_select];
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			auto_reset_enable <= 1'b0;
			irq_enable        <= '0;
		end else if (do_write && w_strb[0]) begin
			if (aw_addr == AUTO_ADDR) begin
				auto_reset_enable <= w_data[0];
			end
			if (aw_addr == IRQ_EN_ADDR) begin
				irq_enable <= w_data[NUM_EVENTS-1:0];
			end
		end
	end

	// Sticky warnings: a crossing in the read cycle survives the clear
	assign next_warn = (ctrl_read ? WARN_RESET : warn) | hit;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			warn <= WARN_RESET;
		end else begin
			warn <= next_warn;
		end
	end

	// One interrupt event per episode; a control read re-arms
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			armed <= 1'b1;
		end else if (irq_set[EV_VIOLATION]) begin
			armed <= 1'b0;
		end else if (ctrl_read) begin
			armed <= 1'b1;
		end
	end

	// Link reset pulse while the option is on and a warning newly appears
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_link_reset <= 1'b0;
		end else begin
			o_link_reset <= auto_reset_enable && (|(hit & ~warn));
		end
	end

	always_comb begin
		irq_set                = '0;
		irq_set[EV_VIOLATION]  = armed && (|hit);
		irq_set[EV_LINK_RESET] = o_link_reset;
		irq_clr                = '0;
		if (do_write && aw_addr == IRQ_CLR_ADDR && w_strb[0]) begin
			irq_clr = w_data[NUM_EVENTS-1:0];
		end
	end

	// Set wins over a clear written in the same cycle
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			irq_status <= '0;
		end else begin
			irq_status <= (irq_status & ~irq_clr) | irq_set;
		end
	end

	assign o_irq = |(irq_status & irq_enable);

	assign ctrl_word = {monitor_enable, 5'h00, warn};
	assign thr_word  = {2'h0, sample_param, 1'b0, parameter_select,
		threshold_low_high_select,
		sample_param ? sampled : threshold_value_field};

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_rvalid <= 1'b0;
			o_rdata  <= '0;
			o_rresp  <= RESP_OKAY;
		end else if (do_read) begin
			o_rvalid <= 1'b1;
			o_rresp  <= RESP_OKAY;
			o_rdata  <= '0;
			case (i_araddr)
				CTRL_ADDR:     o_rdata <= {16'h0000, ctrl_word};
				THR_ADDR:      o_rdata <= {16'h0000, thr_word};
				AUTO_ADDR:     o_rdata <= {31'h0, auto_reset_enable};
				IRQ_STAT_ADDR: o_rdata <= {30'h0, irq_status};
				IRQ_EN_ADDR:   o_rdata <= {30'h0, irq_enable};
				IRQ_CLR_ADDR:  o_rdata <= '0;
				default:       o_rresp <= RESP_SLVERR;
			endcase
		end else if (i_rready) begin
			o_rvalid <= 1'b0;
		end
	end
endmodule
`default_nettype wire

//--- core/lqm_pkg.sv
package lqm_pkg;
	localparam int         DATA_W          = 32;
	localparam int         ADDR_W          = 8;
	localparam int         PARAM_W         = 8;
	localparam int         NUM_PARAMS      = 5;
	// Control and threshold register indices as printed, byte address four times the index; the rest are byte addresses
	localparam logic [7:0] CTRL_INDEX      = 8'h1d;
	localparam logic [7:0] THR_INDEX       = 8'h1e;
	localparam logic [7:0] AUTO_ADDR       = 8'h7c;
	localparam logic [7:0] IRQ_STAT_ADDR   = 8'h80;
	localparam logic [7:0] IRQ_EN_ADDR     = 8'h84;
	localparam logic [7:0] IRQ_CLR_ADDR    = 8'h88;
	// Control register fields
	localparam int         ENABLE_BIT      = 15;
	localparam logic [9:0] WARN_RESET      = 10'h000;
	// Threshold data register fields
	localparam int         SAMPLE_BIT      = 13;
	localparam int         WRITE_BIT       = 12;
	localparam int         SEL_LSB         = 9;
	localparam int         HILO_BIT        = 8;
	localparam logic [2:0] SEL_EQ_COEFF    = 3'h0;
	localparam logic [2:0] SEL_GAIN        = 3'h1;
	localparam logic [2:0] SEL_WANDER      = 3'h2;
	localparam logic [2:0] SEL_FREQ_OFFSET = 3'h3;
	localparam logic [2:0] SEL_FREQ_CTRL   = 3'h4;
	localparam logic [7:0] THR_LOW_RESET   = 8'h00;
	localparam logic [7:0] THR_HIGH_RESET  = 8'hff;
	localparam logic [7:0] PARAM_MIN       = 8'h00;
	localparam logic [7:0] PARAM_MAX       = 8'hff;
	// Interrupt status bits
	localparam int         EV_VIOLATION    = 0;
	localparam int         EV_LINK_RESET   = 1;
	localparam int         NUM_EVENTS      = 2;
	localparam logic [1:0] RESP_OKAY       = 2'h0;
	localparam logic [1:0] RESP_SLVERR     = 2'h2;
endpackage

//--- testbench/link_quality_threshold_monitor_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n,e,s) begin cmp_count++; if ((s) !== (e)) begin fails++; \
	$display("BAD %s exp %h got %h", n, e, s); end end
module link_quality_threshold_monitor_bench;
	import lqm_pkg::*;
	localparam logic [7:0] A_CTRL = {CTRL_INDEX[5:0], 2'b00};
	localparam logic [7:0] A_THR  = {THR_INDEX[5:0], 2'b00};
	logic        i_clk, i_rst_n, lk, pv_ok, seen;
	logic [7:0]  pv [5];
	logic        awv, wv, brd, arv, rrd, awr, wrd, bv, arr, rv, lrst, irq;
	logic [7:0]  awa, ara;
	logic [31:0] wd, rdat, d;
	logic [1:0]  br, rresp, r;
	int          fails, cmp_count, i;

	link_quality_threshold_monitor link_quality_threshold_monitor_i (
		.i_clk(i_clk), .i_rst_n(i_rst_n), .i_link_100_valid(lk),
		.i_param_valid(pv_ok), .i_equaliser_coeff_param(pv[0]),
		.i_gain_control_param(pv[1]), .i_baseline_wander_param(pv[2]),
		.i_freq_offset_param(pv[3]), .i_freq_control_param(pv[4]),
		.o_link_reset(lrst), .o_irq(irq), .i_awvalid(awv), .o_awready(awr),
		.i_awaddr(awa), .i_wvalid(wv), .o_wready(wrd), .i_wdata(wd),
		.i_wstrb(4'hf), .o_bvalid(bv), .i_bready(brd), .o_bresp(br),
		.i_arvalid(arv), .o_arready(arr), .i_araddr(ara), .o_rvalid(rv),
		.i_rready(rrd), .o_rdata(rdat), .o_rresp(rresp));

	initial begin
		i_clk = 0;
		forever #20 i_clk = ~i_clk;
	end
	always @(posedge i_clk) begin
		if (!i_rst_n) seen <= 0;
		else if (lrst) seen <= 1;
	end

	task test_done;
		$display("compares %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task tend(input string s);
		$display("test %s done, mismatches %0d", s, fails);
	endtask
	task wr(input logic [7:0] a, input logic [31:0] v);
		int n;
		@(posedge i_clk);
		awa <= a; wd <= v; awv <= 1; wv <= 1; brd <= 1;
		for (n = 0; n < 20; n++) begin
			@(posedge i_clk);
			if (awv && awr) awv <= 0;
			if (wv && wrd) wv <= 0;
			if (bv) begin r = br; brd <= 0; break; end
		end
		if (n == 20) begin fails++; test_done; end
	endtask
	task rd(input logic [7:0] a);
		int n;
		@(posedge i_clk);
		ara <= a; arv <= 1; rrd <= 1;
		for (n = 0; n < 20; n++) begin
			@(posedge i_clk);
			if (arv && arr) arv <= 0;
			if (rv) begin d = rdat; r = rresp; rrd <= 0; break; end
		end
		if (n == 20) begin fails++; test_done; end
	endtask
	// Others sit mid-range so only the chosen input can trip
	task hit(input int k, input logic [7:0] v);
		@(posedge i_clk);
		foreach (pv[j]) pv[j] <= (j == k) ? v : 8'h80;
		pv_ok <= 1;
		@(posedge i_clk);
		pv_ok <= 0;
		repeat (2) @(posedge i_clk);
	endtask

	initial begin
		i_rst_n = 0; lk = 1; pv_ok = 0; fails = 0; cmp_count = 0;
		awv = 0; wv = 0; brd = 0; arv = 0; rrd = 0; awa = 0; ara = 0; wd = 0;
		foreach (pv[j]) pv[j] = 8'h80;
		repeat (10) @(posedge i_clk);
		i_rst_n <= 1;
		rd(A_CTRL); `CHK("ctrl reset", 32'h0, d)
		rd(A_THR); `CHK("strobe", 1'b0, d[12])
		rd(8'h90); `CHK("unmapped rd", RESP_SLVERR, r)
		wr(8'h90, 32'hffff); `CHK("unmapped wr", RESP_SLVERR, r)
		wr(A_CTRL, 32'hffff); `CHK("wr ok", RESP_OKAY, r)
		rd(A_CTRL); `CHK("ctrl", 32'h8000, d)
		tend("registers");
		for (i = 0; i < 5; i++) begin
			hit(i, PARAM_MAX);
			hit(i, PARAM_MIN);
		end
		rd(A_CTRL); `CHK("extremes", 32'h8000, d)
		for (i = 0; i < 5; i++) begin
			wr(A_THR, {19'h0, 1'b1, i[2:0], 1'b0, 8'h40});
			wr(A_THR, {19'h0, 1'b1, i[2:0], 1'b1, 8'hc0});
		end
		for (i = 0; i < 5; i++) begin
			hit(i, 8'hc1); rd(A_CTRL);
			`CHK("high", 32'h8000 | (32'h2 << 2 * i), d)
			hit(i, 8'h3f); rd(A_CTRL);
			`CHK("low", 32'h8000 | (32'h1 << 2 * i), d)
			hit(i, 8'hc0); hit(i, 8'h40); rd(A_CTRL);
			`CHK("edge", 32'h8000, d)
		end
		tend("thresholds");
		lk <= 0; hit(0, 8'hff); rd(A_CTRL); `CHK("no link", 32'h8000, d)
		lk <= 1; wr(A_CTRL, 32'h0);
		hit(0, 8'hff); rd(A_CTRL); `CHK("off", 32'h0, d)
		wr(A_CTRL, 32'h8000);
		tend("enable");
		// Earlier tests left the sticky status set; start from a clean one
		wr(8'h88, 32'h1); wr(8'h84, 32'h1);
		#1 `CHK("irq idle", 1'b0, irq)
		hit(0, 8'hff); #1 `CHK("irq", 1'b1, irq)
		wr(8'h84, 32'h0); #1 `CHK("masked", 1'b0, irq)
		// Status is sticky, so unmasking must show it again
		wr(8'h84, 32'h1); #1 `CHK("unmasked", 1'b1, irq)
		wr(8'h88, 32'h1); #1 `CHK("cleared", 1'b0, irq)
		hit(1, 8'hff); #1 `CHK("disarmed", 1'b0, irq)
		rd(A_CTRL); hit(1, 8'hff); #1 `CHK("rearmed", 1'b1, irq)
		rd(8'h80); `CHK("status", 1'b1, d[0])
		wr(8'h88, 32'h1);
		tend("interrupt");
		`CHK("no auto", 1'b0, seen)
		wr(8'h7c, 32'h1); rd(A_CTRL); hit(2, 8'hff);
		`CHK("auto", 1'b1, seen)
		rd(8'h80); `CHK("auto status", 1'b1, d[1])
		tend("auto reset");
		wr(A_THR, 32'h2400); rd(A_THR); `CHK("sample", 32'h24ff, d)
		// High threshold data without the strobe must not load
		wr(A_THR, 32'h0110); rd(A_CTRL); hit(0, 8'h80); rd(A_CTRL);
		`CHK("no strobe", 32'h8000, d)
		tend("threshold data");
		test_done;
	end
endmodule
`default_nettype wire

//--- testbench/lqm_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module lqm_asserts (
	// Clock and reset
	input wire logic        i_clk,
	input wire logic        i_rst_n,
	// Observed ports
	input wire logic        o_link_reset,
	input wire logic        o_bvalid,
	input wire logic        i_bready,
	input wire logic [1:0]  o_bresp,
	input wire logic        i_arvalid,
	input wire logic        o_arready,
	input wire logic [7:0]  i_araddr,
	input wire logic        o_rvalid,
	input wire logic        i_rready,
	input wire logic [31:0] o_rdata,
	input wire logic [1:0]  o_rresp
);
	logic [7:0] ra;

	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);

	// Remember which register the pending answer belongs to
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			ra <= 8'h00;
		else if (i_arvalid && o_arready)
			ra <= i_araddr;
	end

	sequence ar_take;
		i_arvalid && o_arready;
	endsequence
	sequence rd_wait;
		o_rvalid && !i_rready;
	endsequence

	a_read_answer: assert property (ar_take |=> o_rvalid)
		else $error("read not answered");
	a_ctrl_ok: assert property ((ar_take and i_araddr == 8'h74)
		|=> o_rresp == 2'h0)
		else $error("control read refused");
	a_resv_zero: assert property (o_rvalid && ra == 8'h74
		|-> o_rdata[14:10] == 5'h00 && o_rdata[31:16] == 16'h0000)
		else $error("reserved bits nonzero");
	a_strobe_zero: assert property (o_rvalid && ra == 8'h78 |-> !o_rdata[12])
		else $error("write strobe read as one");
	a_unmapped_err: assert property ((ar_take and i_araddr == 8'h90)
		|=> o_rresp == 2'h2 && o_rdata == 32'h0)
		else $error("unmapped read not refused");
	a_rdata_hold: assert property (rd_wait |=> o_rvalid && $stable(o_rdata))
		else $error("read data dropped");
	a_ar_reopen: assert property (o_rvalid && i_rready |=> o_arready)
		else $error("address not accepted after answer");
	a_bresp_hold: assert property (o_bvalid && !i_bready
		|=> o_bvalid && $stable(o_bresp))
		else $error("write response dropped");
	a_pulse_once: assert property (o_link_reset |=> !o_link_reset)
		else $error("link reset longer than one cycle");
endmodule
bind link_quality_threshold_monitor lqm_asserts lqm_asserts_i (.i_clk,
	.i_rst_n, .o_link_reset, .o_bvalid, .i_bready, .o_bresp, .i_arvalid,
	.o_arready, .i_araddr, .o_rvalid, .i_rready, .o_rdata, .o_rresp);
`default_nettype wire
